// ===== pcc_pad_board.sv
// Board model at the pads: external resistors and the resulting pad level
`timescale 1ns/100ps
module pcc_pad_board (
    // Clock
    input  wire logic        clk,
    // Device pad controls
    input  wire logic [63:0] padOut,
    input  wire logic [63:0] padOeN,
    input  wire logic [63:0] padPullupEn,
    // External resistor per pin, set by the bench
    input  wire logic [63:0] extEn,
    input  wire logic [63:0] extVal,
    // Pad level seen by the device
    output      logic [63:0] padIn
);
    logic [63:0] lastLvl_ff = 64'h0000_0000_0000_0000;  // Known start so floating pads toggle
    // A floating pad flips each cycle, so a stale level never passes for a real one
    always_ff @(posedge clk) begin
        lastLvl_ff <= padIn;
    end
    // Device driver beats the external resistor, which beats the weak pull-up
    assign padIn = (~padOeN & padOut) | (padOeN & extEn & extVal)
                 | (padOeN & ~extEn & padPullupEn) | (padOeN & ~extEn & ~padPullupEn & ~lastLvl_ff);
endmodule // pcc_pad_board

// ===== pcc_pin_cell.sv
// Single pin cell: drive, pull-up and receiver control from its configuration
`timescale 1ns/100ps

module pcc_pin_cell (
    // Configuration
    input  wire pcc_pkg::pcc_cell_cfg_t cfg,
    // Pad
    input  wire logic                   padIn,
    output      pcc_pkg::pcc_pad_ctl_t  ctl,
    output      logic                   readBit
);

    logic driveHigh;
    logic driveLow;

    // Analog pins never drive; open-drain never drives high
    always_comb begin
        driveLow  = cfg.digital & ~cfg.latch;
        driveHigh = cfg.digital & cfg.latch & cfg.pushPull;
    end

    // Pad controls; pull-up only when digital, undriven and not globally disabled
    always_comb begin
        ctl.padOut    = cfg.latch;
        ctl.padOeN    = ~(driveLow | driveHigh);
        ctl.pullupEn  = cfg.digital & ~driveLow & ~driveHigh
                        & ~cfg.pullupDisable;
        ctl.highDrive = cfg.highDrive;
        ctl.rxEn      = cfg.digital;
    end

    // Analog pins read zero; digital pins read the pad level itself
    always_comb begin
        readBit = cfg.digital & padIn;
    end

endmodule // pcc_pin_cell

// ===== pcc_pkg.sv
// Package for the port pin cell configuration block: map, resets, carriers
package pcc_pkg;

    // Port organisation
    localparam int NUM_PORTS      = 8;
    localparam int PORT_WIDTH     = 8;
    localparam int PIN_COUNT_FULL = 57;
    localparam int PIN_COUNT_LITE = 34;

    // Register byte offsets: eight ports, one word per port per per-port kind, then single global and pin-count words
    localparam logic [11:0] OFS_LATCH  = 12'h000;
    localparam logic [11:0] OFS_ADSEL  = 12'h020;
    localparam logic [11:0] OFS_OMODE  = 12'h040;
    localparam logic [11:0] OFS_DRIVE  = 12'h060;
    localparam logic [11:0] OFS_PIN    = 12'h080;
    localparam logic [11:0] OFS_GLOBAL = 12'h0A0;
    localparam logic [11:0] OFS_PRESENT = 12'h0A4;

    // Field positions in the global control word
    localparam int GLB_PUDIS_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_LATCH = 8'hFF;
    localparam logic [7:0] RST_ADSEL = 8'hFF;
    localparam logic [7:0] RST_OMODE = 8'h00;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic       RST_PUDIS = 1'b0;

    // Register kinds decoded from an address
    typedef enum logic [2:0] {
        REG_LATCH   = 3'b000,
        REG_ADSEL   = 3'b001,
        REG_OMODE   = 3'b010,
        REG_DRIVE   = 3'b011,
        REG_PIN     = 3'b100,
        REG_GLOBAL  = 3'b101,
        REG_PRESENT = 3'b110,
        REG_NONE    = 3'b111
    } pcc_reg_t;

    // Per-pin configuration carried to a pad cell
    typedef struct packed {
        logic latch;
        logic digital;
        logic pushPull;
        logic highDrive;
        logic pullupDisable;
    } pcc_cell_cfg_t;

    // Per-pin pad controls produced by a cell
    typedef struct packed {
        logic padOut;
        logic padOeN;
        logic pullupEn;
        logic highDrive;
        logic rxEn;
    } pcc_pad_ctl_t;

endpackage

// ===== pcc_port_config.sv
// Port pin cell configuration block with an APB register slave
`timescale 1ns/100ps

module pcc_port_config #(
    parameter int PIN_COUNT = pcc_pkg::PIN_COUNT_FULL
) (
    // Clock and reset
    input  wire  logic                                clk,
    input  wire  logic                                rstn,
    // APB slave
    input  wire  logic                                psel,
    input  wire  logic                                penable,
    input  wire  logic                                pwrite,
    input  wire  logic [11:0]                         paddr,
    input  wire  logic [31:0]                         pwdata,
    input  wire  logic [3:0]                          pstrb,
    output       logic                                pready,
    output       logic [31:0]                         prdata,
    output       logic                                pslverr,
    // Pads, eight pins per port
    input  wire  logic [pcc_pkg::NUM_PORTS*8-1:0]     padIn,
    output       logic [pcc_pkg::NUM_PORTS*8-1:0]     padOut,
    output       logic [pcc_pkg::NUM_PORTS*8-1:0]     padOeN,
    output       logic [pcc_pkg::NUM_PORTS*8-1:0]     padPullupEn,
    output       logic [pcc_pkg::NUM_PORTS*8-1:0]     padHighDrive,
    output       logic [pcc_pkg::NUM_PORTS*8-1:0]     padRxEn,
    // Debug data pin sharing on the eighth port
    input  wire  logic                                debugActive,
    input  wire  logic                                debugDataOut,
    input  wire  logic                                debugDataOeN,
    output       logic                                debugDataIn
);

    localparam int NP = pcc_pkg::NUM_PORTS;
    localparam int NB = NP * 8;

    // Only pin counts that fit the port map and reach the eighth port serve;
    // the checks stand at elaboration so a bad variant never builds
    if (PIN_COUNT != pcc_pkg::PIN_COUNT_FULL &&
        PIN_COUNT != pcc_pkg::PIN_COUNT_LITE) begin : gBadCount
        $error("pcc_port_config: PIN_COUNT must be 57 or 34");
    end
    if (pcc_pkg::PORT_WIDTH != 8) begin : gBadWidth
        $error("pcc_port_config: ports must be one byte wide");
    end
    if (pcc_pkg::NUM_PORTS != 8) begin : gBadPorts
        $error("pcc_port_config: the port map needs eight ports");
    end

    // Which pins exist: 34-pin variant keeps the low pins plus the debug pin
    function automatic logic [NB-1:0] present_mask(input int cnt);
        logic [NB-1:0] m;
        m = '0;
        for (int i = 0; i < NB - 8; i++) begin
            if (i < cnt - 1)
                m[i] = 1'b1;
        end
        m[NB-8] = 1'b1;
        return m;
    endfunction

    localparam logic [NB-1:0] PRESENT = present_mask(PIN_COUNT);

    // Address decode used by both the write and read paths
    function automatic pcc_pkg::pcc_reg_t decode_kind(input logic [11:0] a);
        logic [11:0] base;
        base = {a[11:5], 5'b00000};
        if (a[1:0] != 2'b00)
            return pcc_pkg::REG_NONE;
        if (a == pcc_pkg::OFS_GLOBAL)
            return pcc_pkg::REG_GLOBAL;
        if (a == pcc_pkg::OFS_PRESENT)
            return pcc_pkg::REG_PRESENT;
        case (base)
            pcc_pkg::OFS_LATCH: return pcc_pkg::REG_LATCH;
            pcc_pkg::OFS_ADSEL: return pcc_pkg::REG_ADSEL;
            pcc_pkg::OFS_OMODE: return pcc_pkg::REG_OMODE;
            pcc_pkg::OFS_DRIVE: return pcc_pkg::REG_DRIVE;
            pcc_pkg::OFS_PIN:   return pcc_pkg::REG_PIN;
            default:            return pcc_pkg::REG_NONE;
        endcase
    endfunction

    // Configuration state
    logic [NB-1:0] latch_ff;
    logic [NB-1:0] adSel_ff;
    logic [NB-1:0] oMode_ff;
    logic [NB-1:0] drive_ff;
    logic          pullupGlobalDisable_ff;

    // Bus response state
    logic          pready_ff;
    logic [31:0]   prdata_ff;
    logic          pslverr_ff;

    // Pad outputs held in flip-flops
    logic [NB-1:0] padOut_ff;
    logic [NB-1:0] padOeN_ff;
    logic [NB-1:0] padPullupEn_ff;
    logic [NB-1:0] padHighDrive_ff;
    logic [NB-1:0] padRxEn_ff;
    logic          debugDataIn_ff;

    // Combinational cell results
    logic [NB-1:0] nxt_padOut;
    logic [NB-1:0] nxt_padOeN;
    logic [NB-1:0] nxt_padPullupEn;
    logic [NB-1:0] nxt_padHighDrive;
    logic [NB-1:0] nxt_padRxEn;
    logic [NB-1:0] pinRead;

    pcc_pkg::pcc_reg_t kind;
    logic [2:0]        portSel;
    logic              setupPhase;
    logic              wrStrobe;
    logic [7:0]        wrByte;

    // Answer in the first access cycle; writes land on that same edge
    always_comb begin
        kind       = decode_kind(paddr);
        portSel    = paddr[4:2];
        setupPhase = psel & ~penable;
        wrStrobe   = psel & penable & pwrite & pready_ff & pstrb[0]
                     & (kind != pcc_pkg::REG_NONE);
        wrByte     = pwdata[7:0];
    end

    // Ready pulses for one cycle during each access phase
    always_ff @(posedge clk) begin
        if (!rstn)
            pready_ff <= 1'b0;
        else
            pready_ff <= setupPhase;
    end

    // Output latches; eight-pin ports written as bytes, absent pins ignored
    always_ff @(posedge clk) begin
        if (!rstn)
            latch_ff <= {NP{pcc_pkg::RST_LATCH}} & PRESENT;
        else if (wrStrobe && kind == pcc_pkg::REG_LATCH)
            latch_ff[portSel*8 +: 8] <= wrByte & PRESENT[portSel*8 +: 8];
    end

    // Analog/digital select; the debug pin stays digital whatever is written
    always_ff @(posedge clk) begin
        if (!rstn)
            adSel_ff <= {NP{pcc_pkg::RST_ADSEL}} & PRESENT;
        else if (wrStrobe && kind == pcc_pkg::REG_ADSEL) begin
            adSel_ff[portSel*8 +: 8] <= wrByte & PRESENT[portSel*8 +: 8];
            if (portSel == 3'(NP - 1))
                adSel_ff[NB-8] <= 1'b1;
        end
    end

    // Output mode select; reset leaves open-drain with latch high, i.e. released
    always_ff @(posedge clk) begin
        if (!rstn)
            oMode_ff <= {NP{pcc_pkg::RST_OMODE}};
        else if (wrStrobe && kind == pcc_pkg::REG_OMODE)
            oMode_ff[portSel*8 +: 8] <= wrByte & PRESENT[portSel*8 +: 8];
    end

    // Drive strength select, low strength after reset
    always_ff @(posedge clk) begin
        if (!rstn)
            drive_ff <= {NP{pcc_pkg::RST_DRIVE}};
        else if (wrStrobe && kind == pcc_pkg::REG_DRIVE)
            drive_ff[portSel*8 +: 8] <= wrByte & PRESENT[portSel*8 +: 8];
    end

    // Global weak pull-up disable
    always_ff @(posedge clk) begin
        if (!rstn)
            pullupGlobalDisable_ff <= pcc_pkg::RST_PUDIS;
        else if (wrStrobe && kind == pcc_pkg::REG_GLOBAL)
            pullupGlobalDisable_ff <= wrByte[pcc_pkg::GLB_PUDIS_BIT];
    end

    // One cell per pin; absent pins are forced released and inert
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : gCell
            pcc_pkg::pcc_cell_cfg_t cellCfg;
            pcc_pkg::pcc_pad_ctl_t  cellCtl;
            logic                   cellRead;

            always_comb begin
                cellCfg.latch         = latch_ff[gi];
                cellCfg.digital       = adSel_ff[gi];
                cellCfg.pushPull      = oMode_ff[gi];
                cellCfg.highDrive     = drive_ff[gi];
                cellCfg.pullupDisable = pullupGlobalDisable_ff;
            end

            pcc_pin_cell uCell (
                .cfg     (cellCfg),
                .padIn   (padIn[gi]),
                .ctl     (cellCtl),
                .readBit (cellRead)
            );

            always_comb begin
                nxt_padOut[gi]       = cellCtl.padOut & PRESENT[gi];
                nxt_padOeN[gi]       = cellCtl.padOeN | ~PRESENT[gi];
                nxt_padPullupEn[gi]  = cellCtl.pullupEn & PRESENT[gi];
                nxt_padHighDrive[gi] = cellCtl.highDrive & PRESENT[gi];
                nxt_padRxEn[gi]      = cellCtl.rxEn & PRESENT[gi];
                pinRead[gi]          = cellRead & PRESENT[gi];
            end
        end
    endgenerate

    // Pad drive value and enable; debug owns the shared pin while it is active
    always_ff @(posedge clk) begin
        if (!rstn) begin
            padOut_ff <= '0;
            padOeN_ff <= '1;
        end else begin
            padOut_ff <= nxt_padOut;
            padOeN_ff <= nxt_padOeN;
            if (debugActive) begin
                padOut_ff[NB-8] <= debugDataOut;
                padOeN_ff[NB-8] <= debugDataOeN;
            end
        end
    end

    // Weak pull-ups; under debug the shared pin keeps its pull-up only while released
    always_ff @(posedge clk) begin
        if (!rstn) begin
            padPullupEn_ff <= '0;
        end else begin
            padPullupEn_ff <= nxt_padPullupEn;
            if (debugActive)
                padPullupEn_ff[NB-8] <= debugDataOeN & ~pullupGlobalDisable_ff;
        end
    end

    // Strength and receiver enables follow the cells; kept apart from the drive path
    always_ff @(posedge clk) begin
        if (!rstn) begin
            padHighDrive_ff <= '0;
            padRxEn_ff      <= '0;
        end else begin
            padHighDrive_ff <= nxt_padHighDrive;
            padRxEn_ff      <= nxt_padRxEn;
        end
    end

    // Debug receiver sees the shared pad directly
    always_ff @(posedge clk) begin
        if (!rstn)
            debugDataIn_ff <= 1'b0;
        else
            debugDataIn_ff <= padIn[NB-8];
    end

    // Read data captured in setup so it stands through the access cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setupPhase) begin
            pslverr_ff <= (kind == pcc_pkg::REG_NONE);
            case (kind)
                pcc_pkg::REG_LATCH:   prdata_ff <= {24'h00_0000, latch_ff[portSel*8 +: 8]};
                pcc_pkg::REG_ADSEL:   prdata_ff <= {24'h00_0000, adSel_ff[portSel*8 +: 8]};
                pcc_pkg::REG_OMODE:   prdata_ff <= {24'h00_0000, oMode_ff[portSel*8 +: 8]};
                pcc_pkg::REG_DRIVE:   prdata_ff <= {24'h00_0000, drive_ff[portSel*8 +: 8]};
                pcc_pkg::REG_PIN:     prdata_ff <= {24'h00_0000, pinRead[portSel*8 +: 8]};
                pcc_pkg::REG_GLOBAL:  prdata_ff <= {31'h0000_0000, pullupGlobalDisable_ff};
                pcc_pkg::REG_PRESENT: prdata_ff <= {24'h00_0000, 8'(PIN_COUNT)};
                default:              prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Outputs straight from flip-flops, except pslverr, which is gated by the ready flip-flop
    assign pready       = pready_ff;
    assign prdata       = prdata_ff;
    assign pslverr      = pslverr_ff & pready_ff;
    assign padOut       = padOut_ff;
    assign padOeN       = padOeN_ff;
    assign padPullupEn  = padPullupEn_ff;
    assign padHighDrive = padHighDrive_ff;
    assign padRxEn      = padRxEn_ff;
    assign debugDataIn  = debugDataIn_ff;

endmodule // pcc_port_config

// ===== pcc_port_config_props.sv
// Port-level checks for the port pin cell configuration block
`timescale 1ns/100ps
module pcc_port_config_props #(
    parameter int PIN_COUNT = 57
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pads
    input wire logic [63:0] padIn,
    input wire logic [63:0] padOut,
    input wire logic [63:0] padOeN,
    input wire logic [63:0] padPullupEn,
    input wire logic [63:0] padRxEn,
    // Debug
    input wire logic        debugDataIn
);
    // Pins that the variant lacks, in ports 4 to 7
    localparam logic [63:0] ABSENT = ((64'h1 << 56) - (64'h1 << (PIN_COUNT - 1)))
                                   | 64'hFE00_0000_0000_0000;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Setup then a single ready access cycle
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence answerPhase;
        psel && penable && pready;
    endsequence
    ready_after_setup_a: assert property (setupPhase |=> answerPhase)
        else $error("no ready in the access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    error_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without ready or with data");
    read_byte_only_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data beyond one byte");
    reset_release_a: assert property ($rose(rstn) |-> &padOeN && !pready)
        else $error("pads driven straight after reset");
    analog_quiet_a: assert property ((padPullupEn & ~padRxEn) == 64'h0000_0000_0000_0000)
        else $error("pull-up on with receiver off");
    pullup_hiz_only_a: assert property ((padPullupEn & ~padOeN) == 64'h0000_0000_0000_0000)
        else $error("pull-up on while driving");
    absent_pins_off_a: assert property ((padOeN & ABSENT) == ABSENT && (padOut & ABSENT) == 64'h0)
        else $error("absent pin driven");
    debug_pin_digital_a: assert property ($past(rstn) |-> padRxEn[56])
        else $error("debug pin receiver off");
    debug_copy_a: assert property (rstn |=> debugDataIn == $past(padIn[56]))
        else $error("debug data not a copy of the pad");
endmodule // pcc_port_config_props

bind pcc_port_config pcc_port_config_props #(.PIN_COUNT(PIN_COUNT)) props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
    .padPullupEn(padPullupEn), .padRxEn(padRxEn), .debugDataIn(debugDataIn));

// ===== tb_top.sv
// Self-checking testbench for the port pin cell configuration block
`timescale 1ns/100ps
module tb_top;
    // One port 0 setting beside the pad state it should give
    typedef struct packed {
        logic [7:0] latch, adSel, oMode, drive;
        logic       pudis;
        logic [7:0] ext, out, oeN, pu, hd, rx, rd;
    } pcc_row_t;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        debugActive, debugDataOut, debugDataOeN, debugDataIn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic [63:0] padIn, padOut, padOeN, padPullupEn, padHighDrive, padRxEn, extEn, extVal;
    int          errors, checks;
    // Analog row keeps drivers off, as software is expected to
    pcc_row_t rows [5] = '{
        '{8'hA5, 8'hFF, 8'h0F, 8'h3C, 1'b0, 8'h00, 8'hA5, 8'hA0, 8'hA0, 8'h3C, 8'hFF, 8'h05},
        '{8'hFF, 8'hFF, 8'h00, 8'hC3, 1'b1, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hC3, 8'hFF, 8'hFF},
        '{8'hFF, 8'h0F, 8'h00, 8'h00, 1'b0, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h0F, 8'h0F},
        '{8'h00, 8'hFF, 8'h55, 8'hFF, 1'b0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{8'hFF, 8'hFF, 8'hFF, 8'h00, 1'b0, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF}};

    pcc_port_config dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
        .padPullupEn(padPullupEn), .padHighDrive(padHighDrive), .padRxEn(padRxEn),
        .debugActive(debugActive), .debugDataOut(debugDataOut),
        .debugDataOeN(debugDataOeN), .debugDataIn(debugDataIn));
    pcc_pad_board board (.clk(clk), .padOut(padOut), .padOeN(padOeN),
        .padPullupEn(padPullupEn), .extEn(extEn), .extVal(extVal), .padIn(padIn));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; the request is held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("ready wait", 8'(n), 8'h01);
    endtask
    task automatic rdchk(input string what, input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(what, rdata[7:0], exp);
    endtask
    // Verdict and end of run
    task automatic print_verdict();
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        $display("ERROR watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        errors = 0;
        checks = 0;
        {rstn, psel, penable, pwrite, debugActive, debugDataOut} = 6'h00;
        debugDataOeN = 1'b1;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb  = 4'hF;
        extEn  = 64'hFFFF_FFFF_FFFF_FF00;
        extVal = 64'hFFFF_FFFF_FFFF_FFFF;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        // Table of port 0 settings
        foreach (rows[i]) begin
            if (i == 0) begin
                repeat (2) @(posedge clk);
                #1;
                chk("oeN reset", padOeN[7:0], 8'hFF);
                chk("pull-up reset", padPullupEn[7:0], 8'hFF);
                chk("drive reset", padHighDrive[7:0], 8'h00);
                chk("debug in reset", {7'h00, debugDataIn}, 8'h01);
                rdchk("pin reset", pcc_pkg::OFS_PIN, 8'hFF);
                rdchk("latch reset", pcc_pkg::OFS_LATCH, 8'hFF);
                rdchk("select reset", pcc_pkg::OFS_ADSEL, 8'hFF);
                rdchk("mode reset", pcc_pkg::OFS_OMODE, 8'h00);
                rdchk("strength reset", pcc_pkg::OFS_DRIVE, 8'h00);
                rdchk("global reset", pcc_pkg::OFS_GLOBAL, 8'h00);
                extEn[7:0] <= 8'hFF;
            end
            extVal[7:0] <= rows[i].ext;
            apb(1'b1, pcc_pkg::OFS_LATCH, {24'h00_0000, rows[i].latch});
            apb(1'b1, pcc_pkg::OFS_ADSEL, {24'h00_0000, rows[i].adSel});
            apb(1'b1, pcc_pkg::OFS_OMODE, {24'h00_0000, rows[i].oMode});
            apb(1'b1, pcc_pkg::OFS_DRIVE, {24'h00_0000, rows[i].drive});
            apb(1'b1, pcc_pkg::OFS_GLOBAL, {31'h0000_0000, rows[i].pudis});
            repeat (2) @(posedge clk);
            #1;
            chk("pad out", padOut[7:0], rows[i].out);
            chk("pad oeN", padOeN[7:0], rows[i].oeN);
            chk("pull-up", padPullupEn[7:0], rows[i].pu);
            chk("strength", padHighDrive[7:0], rows[i].hd);
            chk("receiver", padRxEn[7:0], rows[i].rx);
            rdchk("pin read", pcc_pkg::OFS_PIN, rows[i].rd);
        end
        // Refused and read-only accesses
        pstrb <= 4'hE;
        apb(1'b1, pcc_pkg::OFS_LATCH, 32'h0000_0000);
        pstrb <= 4'hF;
        rdchk("masked write", pcc_pkg::OFS_LATCH, 8'hFF);
        apb(1'b1, pcc_pkg::OFS_PIN, 32'h0000_0000);
        chk("pin write err", {7'h00, err}, 8'h00);
        rdchk("unmapped", 12'h0A8, 8'h00);
        chk("unmapped err", {7'h00, err}, 8'h01);
        apb(1'b1, 12'h001, 32'h0000_0000);
        chk("unaligned err", {7'h00, err}, 8'h01);
        // Eighth port, pin count and the seventh port
        apb(1'b1, pcc_pkg::OFS_ADSEL + 12'h01C, 32'h0000_0000);
        rdchk("debug pin select", pcc_pkg::OFS_ADSEL + 12'h01C, 8'h01);
        rdchk("pin count", pcc_pkg::OFS_PRESENT, 8'h39);
        apb(1'b1, pcc_pkg::OFS_LATCH + 12'h018, 32'h0000_0000);
        debugActive  <= 1'b1;
        debugDataOut <= 1'b0;
        debugDataOeN <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("port 6 oeN", padOeN[55:48], 8'h00);
        chk("debug drive", {6'h00, padOut[56], padOeN[56]}, 8'h00);
        chk("debug in", {7'h00, debugDataIn}, 8'h00);
        // Reset in mid-run restores the defaults; driven on an edge like every input
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk("latch re-reset", pcc_pkg::OFS_LATCH, 8'hFF);
        print_verdict();
    end
endmodule // tb_top
